// [hdl/io_cycle_wait_state_glue.sv]
// Function
// - Peripheral select low only for decoded address with I/O request active.
// - Matched grades need no waits; optional extra waits absorb system delays.
// - Same wait count for reads and writes keeps the generator simple.
// - Waits counted in clocks, on every I/O cycle or peripheral ones only.
// - Fast processor: delay read strobe fall to a rising clock edge.
// - Fast processor: delay write strobe fall to a rising clock edge.
// - Read waits until address-to-data and strobe-to-data delays have passed.
// - Write waits until the write strobe has been low long enough.
// - Fast processor, slow peripheral: two extra waits per write cycle.
// - Fast processor, fast peripheral: one extra wait per read cycle.
// - Fast processor, fast peripheral: one extra wait per write cycle.
// - Interrupt acknowledge held inactive and stable through the peripheral strobe.
`timescale 1ns/1ns
`include "io_glue_defines.svh"

module io_cycle_wait_state_glue (
	// Clock and reset
	input wire logic core_clk,
	input wire logic clkEn,
	input wire logic nrst,
	// Processor bus, clocked by the system clock
	input wire io_glue_pkg::cpu_bus_t cpuBus,
	output logic cpuWaitN,
	// Peripheral register port
	output io_glue_pkg::periph_bus_t periphBus,
	// Board straps
	input wire io_glue_pkg::strap_t strapPins,
	// Status
	output logic cycleBusy
);
	import io_glue_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		cycle_state_t phase;
		logic isWrite;
		logic isPeriph;
		logic rdDelayed;
		logic wrDelayed;
		logic [3:0] waitStates;
		logic waitN;
	} glue_state_t;

	glue_state_t state_r;
	glue_state_t state_nxt;

	strap_t straps;
	logic [`STRAP_WIDTH-1:0] strapSync;
	logic ioCycle;
	logic periphHit;
	logic cycleStart;
	logic cycleActive;
	logic strobeLow;
	logic cpuStrobeLow;
	logic counterBusy;
	logic [3:0] readWaits;
	logic [3:0] writeWaits;
	logic [3:0] chosenWaits;
	logic [`CNT_WIDTH-1:0] startTarget;
	logic [`CNT_WIDTH-1:0] strobeTarget;
	logic rdOut;
	logic wrOut;

	// ****************************************
	// Straps are board pins, so they are synchronised
	// ****************************************
	strap_sync u_strap_sync (
		.core_clk(core_clk),
		.clkEn(clkEn),
		.nrst(nrst),
		.pinIn(strapPins),
		.syncOut(strapSync)
	);

	assign straps = strap_t'(strapSync);

	// ****************************************
	// Cycle qualification
	// ****************************************
	// Interrupt acknowledge uses I/O request with M1; not an I/O cycle here
	assign ioCycle = !cpuBus.ioRequestN && cpuBus.m1N;
	assign periphHit = ioCycle && cpuBus.addrHit;
	assign cpuStrobeLow = !cpuBus.rdN || !cpuBus.wrN;

	// ****************************************
	// Wait states per grade pairing
	// ****************************************
	always_comb begin
		readWaits = `WS_MATCHED;
		writeWaits = `WS_MATCHED;
		if (straps.fastCpu) begin
			if (straps.fastPeriph) begin
				readWaits = `WS_FAST_FAST_READ;
				writeWaits = `WS_FAST_FAST_WRITE;
			end else begin
				readWaits = `WS_FAST_SLOW_READ;
				writeWaits = `WS_FAST_SLOW_WRITE;
			end
		end
		readWaits = readWaits + {2'b00, straps.extraWaits};
		writeWaits = writeWaits + {2'b00, straps.extraWaits};
		if (straps.sameWaits) begin
			// Larger of the two, so neither direction is shortchanged
			if (readWaits > writeWaits) begin
				writeWaits = readWaits;
			end else begin
				readWaits = writeWaits;
			end
		end
	end

	// ****************************************
	// Cycle sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		cycleStart = 1'b0;
		case (state_r.phase)
			CYC_IDLE: begin
				// Direction known once a strobe shows; wait states apply from then
				if (ioCycle && cpuStrobeLow && (periphHit || straps.waitAllIo)) begin
					cycleStart = 1'b1;
					state_nxt.phase = CYC_ACTIVE;
					state_nxt.isWrite = !cpuBus.wrN;
					state_nxt.isPeriph = periphHit;
					state_nxt.waitStates = !cpuBus.wrN ? writeWaits : readWaits;
				end
			end
			CYC_ACTIVE: begin
				if (cpuBus.ioRequestN) begin
					state_nxt.phase = CYC_IDLE;
				end else if (!counterBusy) begin
					state_nxt.phase = CYC_DONE;
				end
			end
			CYC_DONE: begin
				if (cpuBus.ioRequestN) begin
					state_nxt.phase = CYC_IDLE;
				end
			end
			default: begin
				state_nxt.phase = CYC_IDLE;
			end
		endcase

		// Fall resolved on a rising clock edge, rise passes at once
		state_nxt.rdDelayed = !cpuBus.rdN && ioCycle;
		state_nxt.wrDelayed = !cpuBus.wrN && ioCycle;
		state_nxt.waitN = !(cycleStart || (state_r.phase == CYC_ACTIVE && counterBusy && !cpuBus.ioRequestN));
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_r <= '{phase: CYC_IDLE, isWrite: 1'b0, isPeriph: 1'b0, rdDelayed: 1'b0,
				wrDelayed: 1'b0, waitStates: 4'h0, waitN: 1'b1};
		end else if (clkEn) begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Peripheral strobes
	// ****************************************
	always_comb begin
		if (straps.fastCpu && straps.delayRd) begin
			rdOut = !(state_r.rdDelayed && !cpuBus.rdN);
		end else begin
			rdOut = cpuBus.rdN;
		end
		if (straps.fastCpu && straps.delayWr) begin
			wrOut = !(state_r.wrDelayed && !cpuBus.wrN);
		end else begin
			wrOut = cpuBus.wrN;
		end
	end

	assign periphBus.selectN = !periphHit;
	assign periphBus.rdN = rdOut || !ioCycle;
	assign periphBus.wrN = wrOut || !ioCycle;
	// Acknowledge sequencing is not done here; held inactive and stable
	assign periphBus.interruptAckN = 1'b1;

	// ****************************************
	// Wait timing targets
	// ****************************************
	assign strobeLow = state_r.isWrite ? !periphBus.wrN : !periphBus.rdN;
	assign cycleActive = cycleStart || (state_r.phase == CYC_ACTIVE && !cpuBus.ioRequestN);

	always_comb begin
		chosenWaits = cycleStart ? (!cpuBus.wrN ? writeWaits : readWaits) : state_r.waitStates;
		startTarget = {1'b0, chosenWaits};
		strobeTarget = '0;
		// Peripheral timing only matters for cycles that address it
		if (cycleStart ? periphHit : state_r.isPeriph) begin
			if (cycleStart ? !cpuBus.wrN : state_r.isWrite) begin
				strobeTarget = `CNT_WIDTH'(`WRITE_STROBE_LOW_CYC);
			end else begin
				if (startTarget < `CNT_WIDTH'(`ADDR_TO_READ_DATA_CYC))
					startTarget = `CNT_WIDTH'(`ADDR_TO_READ_DATA_CYC);
				strobeTarget = `CNT_WIDTH'(`READ_STROBE_TO_DATA_CYC);
			end
		end
	end

	wait_counter u_wait_counter (
		.core_clk(core_clk),
		.clkEn(clkEn),
		.nrst(nrst),
		.cycleStart(cycleStart),
		.cycleActive(cycleActive),
		.strobeLow(strobeLow),
		.sinceStartTarget(startTarget),
		.sinceStrobeTarget(strobeTarget),
		.busy(counterBusy)
	);

	// Wait asserted combinationally so the first wait clock is not missed
	assign cpuWaitN = !(cycleActive && counterBusy);
	assign cycleBusy = state_r.phase == CYC_ACTIVE;
endmodule : io_cycle_wait_state_glue

// [pkg/io_glue_defines.svh]
`ifndef IO_GLUE_DEFINES_SVH
`define IO_GLUE_DEFINES_SVH

// ****************************************
// Clock
// ****************************************
`define CLK_PERIOD_NS 40

// ****************************************
// Peripheral timing, ns as printed
// ****************************************
`define ADDR_TO_READ_DATA_DELAY_NS 590
`define READ_STROBE_TO_DATA_DELAY_NS 255
`define WRITE_STROBE_LOW_WIDTH_NS 390

// ****************************************
// Derived cycle counts, least times rounded up
// ****************************************
`define ADDR_TO_READ_DATA_CYC ((`ADDR_TO_READ_DATA_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_STROBE_TO_DATA_CYC ((`READ_STROBE_TO_DATA_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_STROBE_LOW_CYC ((`WRITE_STROBE_LOW_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Wait states per grade pairing
// ****************************************
`define WS_MATCHED 4'h0
`define WS_FAST_SLOW_READ 4'h0
`define WS_FAST_SLOW_WRITE 4'h2
`define WS_FAST_FAST_READ 4'h1
`define WS_FAST_FAST_WRITE 4'h1

// ****************************************
// Field positions of the strap word
// ****************************************
`define STRAP_FAST_CPU 0
`define STRAP_FAST_PERIPH 1
`define STRAP_WAIT_ALL_IO 2
`define STRAP_SAME_WAITS 3
`define STRAP_DELAY_RD 4
`define STRAP_DELAY_WR 5
`define STRAP_EXTRA_LO 6
`define STRAP_EXTRA_HI 7
`define STRAP_WIDTH 8
`define STRAP_RESET 8'h00

// ****************************************
// Counter limits
// ****************************************
`define CNT_WIDTH 5
`define CNT_MAX 5'h1F

`endif

// [pkg/io_glue_pkg.sv]
`include "io_glue_defines.svh"

package io_glue_pkg;

	// ****************************************
	// Processor side pins
	// ****************************************
	typedef struct packed {
		logic ioRequestN;
		logic m1N;
		logic rdN;
		logic wrN;
		logic addrHit;
	} cpu_bus_t;

	// ****************************************
	// Peripheral side pins
	// ****************************************
	typedef struct packed {
		logic selectN;
		logic rdN;
		logic wrN;
		logic interruptAckN;
	} periph_bus_t;

	// ****************************************
	// Board straps
	// ****************************************
	typedef struct packed {
		logic [1:0] extraWaits;
		logic delayWr;
		logic delayRd;
		logic sameWaits;
		logic waitAllIo;
		logic fastPeriph;
		logic fastCpu;
	} strap_t;

	typedef enum logic [1:0] {
		CYC_IDLE = 2'b00,
		CYC_ACTIVE = 2'b01,
		CYC_DONE = 2'b10
	} cycle_state_t;

endpackage : io_glue_pkg

// [hdl/strap_sync.sv]
`timescale 1ns/1ns
`include "io_glue_defines.svh"

module strap_sync (
	// Clock and reset
	input wire logic core_clk,
	input wire logic clkEn,
	input wire logic nrst,
	// Pins
	input wire logic [`STRAP_WIDTH-1:0] pinIn,
	output logic [`STRAP_WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [`STRAP_WIDTH-1:0] ff1;
		logic [`STRAP_WIDTH-1:0] ff2;
		logic [`STRAP_WIDTH-1:0] ff3;
		logic [`STRAP_WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t state_r;
	sync_state_t state_nxt;

	// ****************************************
	// Per bit: accept a change once ff2 and ff3 agree
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < `STRAP_WIDTH; i++) begin : g_bit
			always_comb begin
				state_nxt.ff1[i] = pinIn[i];
				state_nxt.ff2[i] = state_r.ff1[i];
				state_nxt.ff3[i] = state_r.ff2[i];
				state_nxt.stable[i] = (state_r.ff2[i] == state_r.ff3[i]) ? state_r.ff3[i] : state_r.stable[i];
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_r <= '0;
		end else if (clkEn) begin
			state_r <= state_nxt;
		end
	end

	assign syncOut = state_r.stable;
endmodule : strap_sync

// [hdl/wait_counter.sv]
`timescale 1ns/1ns
`include "io_glue_defines.svh"

module wait_counter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic clkEn,
	input wire logic nrst,
	// Cycle tracking
	input wire logic cycleStart,
	input wire logic cycleActive,
	input wire logic strobeLow,
	// Targets in clock periods
	input wire logic [`CNT_WIDTH-1:0] sinceStartTarget,
	input wire logic [`CNT_WIDTH-1:0] sinceStrobeTarget,
	// Result
	output logic busy
);
	typedef struct packed {
		logic [`CNT_WIDTH-1:0] startCnt;
		logic [`CNT_WIDTH-1:0] strobeCnt;
	} cnt_state_t;

	cnt_state_t state_r;
	cnt_state_t state_nxt;

	always_comb begin
		state_nxt = state_r;
		if (cycleStart) begin
			state_nxt.startCnt = `CNT_WIDTH'(1);
			state_nxt.strobeCnt = '0;
		end else if (cycleActive) begin
			if (state_r.startCnt != `CNT_MAX)
				state_nxt.startCnt = state_r.startCnt + `CNT_WIDTH'(1);
			if (strobeLow && state_r.strobeCnt != `CNT_MAX)
				state_nxt.strobeCnt = state_r.strobeCnt + `CNT_WIDTH'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_r <= '0;
		end else if (clkEn) begin
			state_r <= state_nxt;
		end
	end

	// Strobe time only counts once the peripheral strobe is really low
	// Zero targets let the start cycle pass unwaited, as matched grades need
	assign busy = cycleActive && (cycleStart ? (sinceStartTarget != '0 || sinceStrobeTarget != '0) :
		(state_r.startCnt < sinceStartTarget || state_r.strobeCnt < sinceStrobeTarget));
endmodule : wait_counter

// [test/io_glue_sva.sv]
`timescale 1ns/1ns
// ****
// Port checker
// ****
module io_glue_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic clkEn,
	input wire logic nrst,
	// Buses
	input wire io_glue_pkg::cpu_bus_t cpuBus,
	input wire logic cpuWaitN,
	input wire io_glue_pkg::periph_bus_t periphBus,
	input wire io_glue_pkg::strap_t strapPins,
	input wire logic cycleBusy
);
	import io_glue_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	AST_SEL: assert property (periphBus.selectN == !(cpuBus.addrHit && !cpuBus.ioRequestN && cpuBus.m1N))
		else $error("select wrong");
	AST_ACK: assert property (periphBus.interruptAckN == 1'b1)
		else $error("ack not idle");
	AST_RDREL: assert property (cpuBus.rdN |-> periphBus.rdN)
		else $error("read strobe stuck");
	AST_WRREL: assert property (cpuBus.wrN |-> periphBus.wrN)
		else $error("write strobe stuck");
	AST_RDSTROBE: assert property ($fell(periphBus.rdN) && !periphBus.selectN |-> !cpuWaitN [*7])
		else $error("read strobe wait short");
	AST_RDADDR: assert property ($fell(cpuWaitN) && !cpuBus.rdN && !periphBus.selectN
		|-> !cpuWaitN [*8] ##1 !cpuWaitN [*7])
		else $error("read address wait short");
	AST_WRWIDTH: assert property ($fell(periphBus.wrN) && !periphBus.selectN
		|-> !cpuWaitN [*8] ##1 !cpuWaitN [*2])
		else $error("write strobe short");
	AST_WAITEND: assert property ($fell(cpuWaitN) |-> ##[1:40] cpuWaitN)
		else $error("wait never ends");
	AST_WAITQUAL: assert property (!cpuWaitN |-> !cpuBus.ioRequestN && cpuBus.m1N)
		else $error("wait without cycle");
	AST_BUSY: assert property ($rose(cycleBusy) |-> !$past(cpuBus.ioRequestN))
		else $error("busy without cycle");
endmodule : io_glue_sva

bind io_cycle_wait_state_glue io_glue_sva i_io_glue_sva (.core_clk(core_clk), .clkEn(clkEn), .nrst(nrst),
	.cpuBus(cpuBus), .cpuWaitN(cpuWaitN), .periphBus(periphBus), .strapPins(strapPins), .cycleBusy(cycleBusy));

// [test/periph_model.sv]
`timescale 1ns/1ns
// ****
// Peripheral register port
// ****
module periph_model (
	// Clock
	input wire logic core_clk,
	// Register port
	input wire io_glue_pkg::periph_bus_t periphBus,
	input wire logic cpuWaitN,
	// Status
	output int badCount
);
	int selLow = 0;
	int strLow = 0;
	initial badCount = 0;
	always @(posedge core_clk) begin
		selLow <= periphBus.selectN ? 0 : selLow + 1;
		strLow <= (periphBus.selectN || (periphBus.rdN && periphBus.wrN)) ? 0 : strLow + 1;
		// Data is taken as soon as wait lifts
		if (!periphBus.selectN && !periphBus.rdN && cpuWaitN && (selLow < 15 || strLow < 7)) begin
			badCount <= badCount + 1;
		end
		if (!periphBus.selectN && !periphBus.wrN && cpuWaitN && strLow < 10) begin
			badCount <= badCount + 1;
		end
	end
endmodule : periph_model

// [test/tb.sv]
`timescale 1ns/1ns
module tb;
	import io_glue_pkg::*;
	localparam cpu_bus_t IDLE_BUS = 5'h1E;
	logic core_clk;
	logic nrst;
	cpu_bus_t cpuBus;
	strap_t strapPins;
	logic cpuWaitN;
	periph_bus_t periphBus;
	logic cycleBusy;
	int badCount;
	int errors = 0;
	int total_checks = 0;
	io_cycle_wait_state_glue i_io_cycle_wait_state_glue (.core_clk(core_clk), .clkEn(1'b1), .nrst(nrst),
		.cpuBus(cpuBus), .cpuWaitN(cpuWaitN), .periphBus(periphBus), .strapPins(strapPins), .cycleBusy(cycleBusy));
	periph_model i_periph_model (.core_clk(core_clk), .periphBus(periphBus), .cpuWaitN(cpuWaitN), .badCount(badCount));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// ****
	// Helpers
	// ****
	task complete_run;
		if (errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : cmp
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : tick
	// Counts cycles held in wait; also notes select and strobe in the first cycle
	task io_cycle(input logic hit, input logic wr, input logic m1, output logic [7:0] waits, output logic [1:0] first);
		int i;
		waits = 8'h00;
		cpuBus = '{ioRequestN: 1'b0, m1N: m1, rdN: wr, wrN: !wr, addrHit: hit};
		#1;
		first = {periphBus.selectN, wr ? periphBus.wrN : periphBus.rdN};
		cmp({7'h0, cycleBusy}, 8'h00);
		for (i = 0; i < 40 && cpuWaitN !== 1'b1; i++) begin
			waits++;
			tick(1);
			#1;
			cmp({7'h0, cycleBusy}, 8'h01);
		end
		if (i == 40) begin
			errors++;
			complete_run();
		end
		tick(1);
		cpuBus = IDLE_BUS;
		tick(1);
	endtask : io_cycle
	task pair(input strap_t s, input logic [7:0] rdExp, input logic [7:0] wrExp);
		logic [7:0] w;
		logic [1:0] f;
		strapPins = s;
		tick(6);
		io_cycle(1'b0, 1'b0, 1'b1, w, f);
		cmp(w, rdExp);
		io_cycle(1'b0, 1'b1, 1'b1, w, f);
		cmp(w, wrExp);
	endtask : pair
	// ****
	// Scenarios
	// ****
	task sc_select;
		logic [7:0] w;
		logic [1:0] f;
		io_cycle(1'b1, 1'b0, 1'b1, w, f);
		cmp({7'h0, f[1]}, 8'h00);
		io_cycle(1'b1, 1'b0, 1'b0, w, f);
		cmp({7'h0, f[1]}, 8'h01);
		cmp(w, 8'h00);
		io_cycle(1'b0, 1'b1, 1'b1, w, f);
		cmp(w, 8'h00);
	endtask : sc_select
	task sc_periph;
		logic [7:0] w;
		logic [1:0] f;
		strapPins = 8'h33;
		tick(6);
		io_cycle(1'b1, 1'b0, 1'b1, w, f);
		cmp(w, 8'h0F);
		cmp({6'h0, f}, 8'h01);
		io_cycle(1'b1, 1'b1, 1'b1, w, f);
		cmp(w, 8'h0B);
		cmp({6'h0, f}, 8'h01);
		strapPins = 8'h03;
		tick(6);
		io_cycle(1'b1, 1'b0, 1'b1, w, f);
		cmp(w, 8'h0F);
		io_cycle(1'b1, 1'b1, 1'b1, w, f);
		cmp(w, 8'h0B);
	endtask : sc_periph
	task sc_waits;
		pair(8'h04, 8'h00, 8'h00);
		pair(8'hC4, 8'h03, 8'h03);
		pair(8'h05, 8'h00, 8'h02);
		pair(8'h07, 8'h01, 8'h01);
		pair(8'h0D, 8'h02, 8'h02);
	endtask : sc_waits
	initial begin
		nrst = 1'b0;
		cpuBus = IDLE_BUS;
		strapPins = 8'h00;
		tick(10);
		nrst = 1'b1;
		tick(5);
		sc_select();
		sc_periph();
		sc_waits();
		cmp(badCount[7:0], 8'h00);
		complete_run();
	end
endmodule : tb
